// *** src/hbt_target.sv ***
/*
  Target-side cycle logic of a 4-bit nibble-serial hub bus for a byte-wide
  flash: decodes start, select, address and size, inserts sync codes and
  moves one byte as two nibbles; answers identification mode reads.
  Assumes bus inputs synchronous to clk, host keeps the frame pin low only
  on the start clock, and software sets the select value over APB.
*/
`timescale 1ns/1ps
`default_nettype none
module hbt_target (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cycle_frame_pin_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe_n,
  input wire logic top_block_lock_pin_n,
  input wire logic write_protect_pin_n,
  output logic wr_strobe,
  output logic [hbt_pkg::HBT_ADDR_BITS-1:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import hbt_pkg::*;

  hbt_state_t state;
  hbt_state_t next_state;
  logic is_write;
  logic [2:0] cnt;
  logic [3:0] wait_cnt;
  logic [7:0] byte_buf;
  logic id_mode;
  logic size_err;
  logic [6:0] ctrl;
  logic [7:0] array_data;
  logic [HBT_ADDR_BITS-1:0] addr;
  logic [7:0] rd_byte;

  // ==========================================================
  // Field decode
  wire frame = !cycle_frame_pin_n;
  wire start_rd = frame && (lad_in == HBT_START_READ);
  wire start_wr = frame && (lad_in == HBT_START_WRITE);
  wire sel_hit = (lad_in == ctrl[HBT_CTRL_SEL_LSB +: 4]);
  wire size_ok = (lad_in == HBT_SIZE_BYTE);
  wire addr_done = (cnt == HBT_ADDR_LAST);
  wire long_wait = ctrl[HBT_CTRL_LONGW];
  wire wait_done = !long_wait || (wait_cnt == HBT_LONG_WAIT_AFTER);
  wire [7:0] wbyte = {lad_in, byte_buf[3:0]};

  // ==========================================================
  // Phase strobes shared by capture and command logic
  // Every two-clock phase ends on an odd count
  wire second_clk = cnt[0];
  wire wdata_lo = (state == HBT_WDATA) && !second_clk;
  wire wdata_hi = (state == HBT_WDATA) && second_clk;
  // Read byte frozen at the size clock, once the address is whole
  wire rd_load = (state == HBT_SIZE) && !is_write;
  // A write only counts once sync reaches ready without error
  wire wr_commit = (state == HBT_SYNC) && is_write && wait_done && !size_err;
  wire cmd_exit = (byte_buf == HBT_CMD_ID_EXIT);
  wire cmd_entry = (byte_buf == HBT_CMD_ID_ENTRY);

  // ==========================================================
  // Sub-blocks
  hbt_nibble_shift u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .clear(start_rd || start_wr),
    .shift_en(state == HBT_ADDR),
    .nibble(lad_in),
    .addr(addr)
  );

  hbt_id_mux u_mux (
    .id_mode(id_mode),
    .addr(addr),
    .array_data(array_data),
    .sw_lock64(ctrl[HBT_CTRL_LOCK64]),
    .sw_lock16(ctrl[HBT_CTRL_LOCK16]),
    .top_block_lock_pin_n(top_block_lock_pin_n),
    .write_protect_pin_n(write_protect_pin_n),
    .rdata(rd_byte)
  );

  // ==========================================================
  // Next-state logic; a new start frame always restarts the cycle
  // Idle is left only through a new start frame; skip is left on any frame clock
  always_comb begin
    next_state = state;
    unique case (state)
      HBT_IDLE: next_state = HBT_IDLE;
      HBT_SEL: next_state = sel_hit ? HBT_ADDR : HBT_SKIP;
      HBT_ADDR: next_state = addr_done ? HBT_SIZE : HBT_ADDR;
      HBT_SIZE: next_state = is_write ? HBT_WDATA : HBT_TAR_IN;
      HBT_WDATA: next_state = (cnt[0]) ? HBT_TAR_IN : HBT_WDATA;
      HBT_TAR_IN: next_state = cnt[0] ? HBT_SYNC : HBT_TAR_IN;
      HBT_SYNC: next_state = (wait_done && !is_write && !size_err) ? HBT_RDATA :
                             (wait_done ? HBT_TAR_OUT : HBT_SYNC);
      HBT_RDATA: next_state = cnt[0] ? HBT_TAR_OUT : HBT_RDATA;
      HBT_TAR_OUT: next_state = cnt[0] ? HBT_IDLE : HBT_TAR_OUT;
      HBT_SKIP: next_state = HBT_SKIP;
      default: next_state = HBT_IDLE;
    endcase
    if (start_rd || start_wr) begin
      next_state = HBT_SEL;
    end else if (frame) begin
      next_state = HBT_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HBT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter, zeroed on every phase change
  // Free-running in idle and skip; nothing reads it there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (next_state != state) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // Long wait counter and sync wait tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= '0;
    end else if (state != HBT_SYNC) begin
      wait_cnt <= '0;
    end else if (!wait_done) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Cycle capture: direction, size check, write nibbles
  // Direction holds for the whole cycle; a new frame reloads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_write <= 1'b0;
      size_err <= 1'b0;
      byte_buf <= '0;
    end else begin
      if (start_rd || start_wr) begin
        is_write <= start_wr;
      end
      if (state == HBT_SIZE) begin
        size_err <= !size_ok;
      end
      if (wdata_lo) begin
        byte_buf[3:0] <= lad_in;
      end
      if (wdata_hi) begin
        byte_buf <= wbyte;
      end
      if (rd_load) begin
        byte_buf <= rd_byte;
      end
    end
  end

  // ==========================================================
  // Identification mode and write strobe out to the array
  // cleared by reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_mode <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_strobe <= 1'b0;
      if (wr_commit) begin
        if (cmd_exit) begin
          id_mode <= 1'b0;
        end else if (cmd_entry) begin
          id_mode <= 1'b1;
        end else begin
          wr_strobe <= 1'b1;
          wr_addr <= addr;
          wr_data <= byte_buf;
        end
      end
    end
  end

  // ==========================================================
  // Bus drive: sync codes, data nibbles, release
  // Sync nibble for the wait position; an error replaces every wait code
  function automatic logic [3:0] sync_nibble(input logic err, input logic done, input logic [3:0] waited);
    logic [3:0] code;
    code = HBT_SYNC_LONG;
    if (err) begin
      code = HBT_SYNC_ERROR;
    end else if (done) begin
      code = HBT_SYNC_READY;
    end else if (waited == '0) begin
      code = HBT_SYNC_SHORT;
    end
    return code;
  endfunction
  wire [3:0] sync_code = sync_nibble(size_err, wait_done, wait_cnt);
  wire drive = (state == HBT_SYNC) || (state == HBT_RDATA) || (state == HBT_TAR_OUT && !cnt[0]);
  wire [3:0] next_out = (state == HBT_SYNC) ? sync_code :
                        (state == HBT_RDATA) ? (cnt[0] ? byte_buf[7:4] : byte_buf[3:0]) : HBT_NIBBLE_IDLE;

  // Registered so the pins only change just after a clock edge
  // ready at once, or short then long wait codes then ready when long wait is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lad_out <= HBT_NIBBLE_IDLE;
      lad_oe_n <= 1'b1;
    end else begin
      lad_out <= next_out;
      lad_oe_n <= !drive;
    end
  end

  // ==========================================================
  // APB slave, zero wait state
  wire apb_wr = psel && penable && pwrite;
  wire hit = (paddr == HBT_REG_CTRL) || (paddr == HBT_REG_STATUS) || (paddr == HBT_REG_LAST_ADDR) ||
             (paddr == HBT_REG_LAST_DATA) || (paddr == HBT_REG_ARRAY_DATA);
  wire [31:0] rmux = (paddr == HBT_REG_CTRL) ? {25'h0, ctrl} :
                     (paddr == HBT_REG_STATUS) ? {24'h0, ~write_protect_pin_n, ~top_block_lock_pin_n,
                                                  size_err, id_mode, state} :
                     (paddr == HBT_REG_LAST_ADDR) ? {4'h0, wr_addr} :
                     (paddr == HBT_REG_LAST_DATA) ? {24'h0, wr_data} :
                     (paddr == HBT_REG_ARRAY_DATA) ? {24'h0, array_data} : 32'h0;

  // Register writes on the access edge
  // Only seven control bits exist; the rest of the word is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= HBT_CTRL_RESET;
      array_data <= '0;
    end else if (apb_wr && paddr == HBT_REG_CTRL) begin
      ctrl <= pwdata[6:0];
    end else if (apb_wr && paddr == HBT_REG_ARRAY_DATA) begin
      array_data <= pwdata[7:0];
    end
  end

  // Registered answer, ready in setup so access completes at once
  // Trade-off: no wait states, so every register must answer at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= (psel && !penable && !pwrite) ? rmux : 32'h0;
    end
  end
endmodule
`default_nettype wire

// *** include/hbt_pkg.sv ***
/*
  Constants and types for the hub bus target cycle logic: field codes,
  phase lengths, APB register map, mode entry and exit commands and identity values.
  Assumes a single 40 MHz clock and a 32-bit APB master.
*/
package hbt_pkg;

  // ==========================================================
  // Bus field codes
  localparam logic [3:0] HBT_START_READ = 4'hD;
  localparam logic [3:0] HBT_START_WRITE = 4'hE;
  localparam logic [3:0] HBT_SIZE_BYTE = 4'h0;
  localparam logic [3:0] HBT_SYNC_READY = 4'h0;
  localparam logic [3:0] HBT_SYNC_SHORT = 4'h5;
  localparam logic [3:0] HBT_SYNC_LONG = 4'h6;
  localparam logic [3:0] HBT_SYNC_ERROR = 4'hA;
  // Level shown on the nibble outputs while the target does not drive
  localparam logic [3:0] HBT_NIBBLE_IDLE = 4'hF;

  // ==========================================================
  // Phase lengths in clocks and address width in bits
  localparam logic [2:0] HBT_ADDR_CLOCKS = 3'h7;
  localparam logic [2:0] HBT_ADDR_LAST = 3'h6;
  localparam int HBT_ADDR_BITS = 28;
  localparam logic [3:0] HBT_LONG_WAIT_AFTER = 4'h3;

  // ==========================================================
  // Identification mode
  localparam logic [7:0] HBT_CMD_ID_EXIT = 8'hF0;
  localparam logic [7:0] HBT_CMD_ID_ENTRY = 8'h90;
  // Arbitrary identity values, not any real part
  localparam logic [7:0] HBT_MAKER_CODE = 8'hA5;
  localparam logic [7:0] HBT_PART_CODE = 8'h5A;
  localparam int HBT_ID_LO_BIT = 1;
  localparam int HBT_ID_HI_BIT = 18;

  // ==========================================================
  // APB register map (byte addresses)
  localparam logic [7:0] HBT_REG_CTRL = 8'h00;
  localparam logic [7:0] HBT_REG_STATUS = 8'h04;
  localparam logic [7:0] HBT_REG_LAST_ADDR = 8'h08;
  localparam logic [7:0] HBT_REG_LAST_DATA = 8'h0C;
  localparam logic [7:0] HBT_REG_ARRAY_DATA = 8'h10;
  // Control field positions
  localparam int HBT_CTRL_SEL_LSB = 0;
  localparam int HBT_CTRL_LOCK64 = 4;
  localparam int HBT_CTRL_LOCK16 = 5;
  localparam int HBT_CTRL_LONGW = 6;
  localparam logic [6:0] HBT_CTRL_RESET = 7'h00;

  // Bus phase states
  typedef enum logic [3:0] {
    HBT_IDLE = 4'b0000,
    HBT_SEL = 4'b0001,
    HBT_ADDR = 4'b0010,
    HBT_SIZE = 4'b0011,
    HBT_WDATA = 4'b0100,
    HBT_TAR_IN = 4'b0101,
    HBT_SYNC = 4'b0110,
    HBT_RDATA = 4'b0111,
    HBT_TAR_OUT = 4'b1000,
    HBT_SKIP = 4'b1001
  } hbt_state_t;

endpackage

// *** src/hbt_nibble_shift.sv ***
/*
  Address nibble collector: shifts one nibble per clock into a 28-bit
  address, most significant nibble first.
  Assumes the caller raises shift_en for exactly the seven address clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module hbt_nibble_shift (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic [3:0] nibble,
  output logic [hbt_pkg::HBT_ADDR_BITS-1:0] addr
);
  import hbt_pkg::*;

  // ==========================================================
  // Shift register
  // MSB nibble first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
    end else if (clear) begin
      addr <= '0;
    end else if (shift_en) begin
      addr <= {addr[HBT_ADDR_BITS-5:0], nibble};
    end
  end
endmodule
`default_nettype wire

// *** src/hbt_id_mux.sv ***
/*
  Read-data selector for identification mode: maker code, part code and
  the lock status byte; normal array data otherwise.
  Assumes lock inputs are already stable levels in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module hbt_id_mux (
  input wire logic id_mode,
  input wire logic [hbt_pkg::HBT_ADDR_BITS-1:0] addr,
  input wire logic [7:0] array_data,
  input wire logic sw_lock64,
  input wire logic sw_lock16,
  input wire logic top_block_lock_pin_n,
  input wire logic write_protect_pin_n,
  output logic [7:0] rdata
);
  import hbt_pkg::*;

  // ==========================================================
  // Identification decode
  wire id_high_zero = (addr[HBT_ID_HI_BIT:HBT_ID_LO_BIT] == '0);
  wire [7:0] lock_byte = {4'h0, ~write_protect_pin_n, ~top_block_lock_pin_n, sw_lock16, sw_lock64};
  wire [7:0] id_byte = addr[0] ? HBT_PART_CODE : HBT_MAKER_CODE;

  // Lock status answers any address with a nonzero bit in 18..1 while in identification mode
  assign rdata = !id_mode ? array_data : (id_high_zero ? id_byte : lock_byte);
endmodule
`default_nettype wire

// *** tb/hbt_target_props.sv ***
/* Timing checker for the hub bus target cycle logic.
   Assumes it is bound to the target and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module hbt_target_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cycle_frame_pin_n,
  input wire logic [3:0] lad_in,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe_n,
  input wire logic wr_strobe,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Helper state
  logic [4:0] cnt;
  logic [3:0] sel_q;
  logic hit;
  logic rd_q;
  logic sz_bad;
  logic [2:0] post;
  wire logic start;
  wire logic ctl_wr;
  wire logic post_go;
  // Start codes and select shadow; post counts after the first final code
  assign start = !cycle_frame_pin_n && (lad_in == 4'hD || lad_in == 4'hE);
  assign ctl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
  assign post_go = post != 3'h0 || lad_out == 4'h0 || lad_out == 4'hA;
  // Clocks since start, saturating so idle never looks like a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 5'h1F;
    else if (start) cnt <= 5'h00;
    else if (cnt != 5'h1F) cnt <= cnt + 5'h01;
  end
  // Cycle facts taken at the start, select and size clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 4'h0;
      hit <= 1'b0;
      rd_q <= 1'b0;
      sz_bad <= 1'b0;
    end else begin
      if (ctl_wr) sel_q <= pwdata[3:0];
      if (start) hit <= 1'b0;
      else if (cnt == 5'h00) hit <= lad_in == sel_q;
      if (start) rd_q <= lad_in == 4'hD;
      if (cnt == 5'h08) sz_bad <= lad_in != 4'h0;
    end
  end
  // Driven clocks after ready or error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) post <= 3'h0;
    else if (lad_oe_n) post <= 3'h0;
    else if (post_go) post <= post + 3'h1;
  end
  // ==========================================
  // Properties
  unsel_quiet_a: assert property (!hit |-> lad_oe_n) else $error("drive while unselected");
  tar_gap_a: assert property (!lad_oe_n |-> cnt > 5'd10) else $error("drive in turnaround");
  first_code_a: assert property ($fell(lad_oe_n) |-> lad_out inside {4'h0, 4'h5, 4'h6, 4'hA})
    else $error("bad first sync");
  wait_next_a: assert property (!lad_oe_n && post == 3'h0 && lad_out inside {4'h5, 4'h6} |=>
    !lad_oe_n && lad_out inside {4'h0, 4'h5, 4'h6, 4'hA}) else $error("bad code after wait");
  wait_bound_a: assert property ($fell(lad_oe_n) |-> ##[0:8] (lad_out == 4'h0 || lad_out == 4'hA))
    else $error("wait too long");
  size_err_a: assert property ($fell(lad_oe_n) && sz_bad |-> lad_out == 4'hA) else $error("no size error");
  read_tail_a: assert property (rd_q && post == 3'h3 |-> lad_out == 4'hF ##1 lad_oe_n)
    else $error("read tail wrong");
  write_tail_a: assert property (!rd_q && post == 3'h1 |-> ##[0:1] lad_oe_n) else $error("write hold");
  strobe_one_a: assert property (wr_strobe |=> !wr_strobe) else $error("strobe too long");
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  apb_err_a: assert property (psel && penable && pready && paddr > 8'h10 |-> pslverr) else $error("no slverr");
  read_done_c: cover property (rd_q && post == 3'h3);
  long_wait_c: cover property (!lad_oe_n && post == 3'h0 && lad_out == 4'h6);
  size_err_c: cover property ($fell(lad_oe_n) && sz_bad);
  strobe_c: cover property (wr_strobe);
endmodule
`default_nettype wire

// *** tb/hbt_host.sv ***
/* Host controller model: frames cycles and resolves the nibble wire.
   Assumes the target shares clk and drives lad_out while lad_oe_n is low. */
`timescale 1ns/1ps
`default_nettype none
module hbt_host (
  input wire logic clk,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe_n,
  output logic frame_n,
  output logic [3:0] lad
);
  logic [3:0] hv;
  logic [3:0] jv;
  logic ho;
  logic tmo;
  logic [3:0] code;
  logic [2:0] nw;
  logic [7:0] rd;
  initial begin
    frame_n = 1'b1;
    hv = 4'hF;
    jv = 4'h3;
    ho = 1'b1;
  end
  // Released wire changes every clock, so stale data never matches
  always @(posedge clk) jv <= ~jv;
  assign lad = !lad_oe_n ? lad_out : (ho ? hv : jv);
  task automatic put(input logic [3:0] n);
    @(posedge clk);
    ho <= 1'b1;
    hv <= n;
  endtask
  task automatic head(input logic [3:0] s, input logic [3:0] sel, input logic [27:0] a, input logic [3:0] sz);
    put(s);
    frame_n <= 1'b0;
    put(sel);
    frame_n <= 1'b1;
    for (int i = 6; i >= 0; i--) put(a[i*4 +: 4]);
    put(sz);
  endtask
  // host lets go, then waits out the sync codes
  task automatic hear();
    int i;
    @(posedge clk);
    ho <= 1'b0;
    nw = 3'h0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (!lad_oe_n && (lad_out == 4'h5 || lad_out == 4'h6)) nw++;
      else if (!lad_oe_n) break;
    end
    tmo = i == 40;
    code = lad_out;
  endtask
  task automatic rd_cyc(input logic [3:0] sel, input logic [27:0] a, input logic [3:0] sz);
    head(4'hD, sel, a, sz);
    hear();
    @(posedge clk);
    rd[3:0] = lad_out;
    @(posedge clk);
    rd[7:4] = lad_out;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr_cyc(input logic [3:0] sel, input logic [27:0] a, input logic [7:0] d);
    head(4'hE, sel, a, 4'h0);
    put(d[3:0]);
    put(d[7:4]);
    hear();
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_hub_bus_target_cycle_logic.sv ***
/* Self-checking bench for the hub bus target cycle logic.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_hub_bus_target_cycle_logic;
  import hbt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tbl_n = 1'b1;
  logic wp_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cycle_frame_pin_n;
  logic [3:0] lad_in;
  logic [3:0] lad_out;
  logic lad_oe_n;
  logic wr_strobe;
  logic [27:0] wr_addr;
  logic [7:0] wr_data;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int fails = 0;
  int n_checks = 0;
  int n_wr = 0;
  logic [31:0] q;
  logic [31:0] c;
  logic e;
  logic [7:0] b;
  logic [27:0] a;
  always #12.5 clk = ~clk;
  // Array write pulses, counted to show commands never reach the array
  always @(posedge clk) if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
  hbt_host h (.clk(clk), .lad_out(lad_out), .lad_oe_n(lad_oe_n), .frame_n(cycle_frame_pin_n), .lad(lad_in));
  hbt_target dut (.clk(clk), .rst_n(rst_n), .cycle_frame_pin_n(cycle_frame_pin_n), .lad_in(lad_in),
    .lad_out(lad_out), .lad_oe_n(lad_oe_n), .top_block_lock_pin_n(tbl_n), .write_protect_pin_n(wp_n),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded APB transfer; leaves read data and error in q and e
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) fails++;
    if (i == 20) wrap_up();
  endtask
  task automatic bus_ok(input logic t);
    check(h.tmo, t);
    if (h.tmo !== t) wrap_up();
  endtask
  task automatic brd(input logic [3:0] s, input logic [27:0] ad, input logic [3:0] sz, input logic t);
    h.rd_cyc(s, ad, sz);
    bus_ok(t);
  endtask
  function automatic logic [3:0] lock_exp(input logic [31:0] cv, input logic t, input logic w);
    return {~w, ~t, cv[5], cv[4]};
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    q = $urandom(55);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, HBT_REG_CTRL, 32'h3);
    apb(1'b0, HBT_REG_CTRL, 32'h0);
    check(q[6:0], 7'h03);
    apb(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    check({31'h0, e}, 32'h1);
    // Random reads and writes, all-ones address first
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      a = (i == 0) ? 28'hFFFFFFF : 28'($urandom);
      apb(1'b1, HBT_REG_ARRAY_DATA, {24'h0, b});
      brd(4'h3, a, 4'h0, 1'b0);
      check(h.code, HBT_SYNC_READY);
      check(h.rd, b);
      check(h.nw, 3'h0);
      h.wr_cyc(4'h3, a, b & 8'h7F);
      bus_ok(1'b0);
      check(wr_addr, a);
      check(wr_data, b & 8'h7F);
    end
    check(n_wr, 32'd6);
    brd(4'h4, a, 4'h0, 1'b1);
    brd(4'h3, a, 4'h1, 1'b0);
    check(h.code, HBT_SYNC_ERROR);
    apb(1'b1, HBT_REG_CTRL, 32'h43);
    brd(4'h3, a, 4'h0, 1'b0);
    check({h.nw, h.rd}, {HBT_LONG_WAIT_AFTER[2:0], b});
    // Identification codes, then lock bits under every pin setting
    h.wr_cyc(4'h3, a, HBT_CMD_ID_ENTRY);
    apb(1'b0, HBT_REG_STATUS, 32'h0);
    check(q[4], 1'b1);
    brd(4'h3, 28'h0, 4'h0, 1'b0);
    check(h.rd, HBT_MAKER_CODE);
    brd(4'h3, 28'h1, 4'h0, 1'b0);
    check(h.rd, HBT_PART_CODE);
    for (int j = 0; j < 4; j++) begin
      c = {26'h0, 2'($urandom), 4'h3};
      apb(1'b1, HBT_REG_CTRL, c);
      tbl_n <= j[0];
      wp_n <= j[1];
      brd(4'h3, 28'h2, 4'h0, 1'b0);
      check(h.rd[3:0], lock_exp(c, j[0], j[1]));
    end
    h.wr_cyc(4'h3, 28'h1234567, HBT_CMD_ID_EXIT);
    check(n_wr, 32'd6);
    brd(4'h3, 28'h0, 4'h0, 1'b0);
    check(h.rd, b);
    // Reset in mid-run drops identification mode
    h.wr_cyc(4'h3, a, HBT_CMD_ID_ENTRY);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, HBT_REG_CTRL, 32'h3);
    apb(1'b1, HBT_REG_ARRAY_DATA, {24'h0, b});
    brd(4'h3, 28'h0, 4'h0, 1'b0);
    check(h.rd, b);
    apb(1'b0, HBT_REG_STATUS, 32'h0);
    check(q[4], 1'b0);
    wrap_up();
  end
endmodule
bind hbt_target hbt_target_props chk (.clk(clk), .rst_n(rst_n), .cycle_frame_pin_n(cycle_frame_pin_n),
  .lad_in(lad_in), .lad_out(lad_out), .lad_oe_n(lad_oe_n), .wr_strobe(wr_strobe), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
